/* core/sfrm_defs.svh */
// opcodes, field masks, reset values and timing for the flash front end
// Function
// - no-op only cancels an armed reset
// - reset needs arm frame then reset frame
// - any other command disarms a pending reset
// - reset restores 1-bit, 8-byte burst, status except bits 5:4
// - reset clears the quad io enable bit
// - reset during write aborts that write
// - recovery after aborted write lasts longer
// - slow read only in 1-bit protocol
// - slow read: opcode, 24 address bits, data
// - read streams incrementing, wraps at top
// - enter-quad opcode switches to 4-bit protocol
// - quad exit in own frame, either width
// - quad exit in continuation only leaves continuation
// - power-up 1-bit; fast read in both
// - 1-bit fast read adds one dummy byte
// - 4-bit fast read: address, mode, two dummies
// - 4-bit data driven on falling clock edge
// - 4-bit read pointer wraps to zero
// - read-locked bytes return zero
// - mode nibble A skips next opcode
// - other mode values expect full opcode
// - cycle is two or eight clocks
`ifndef SFRM_DEFS_SVH
`define SFRM_DEFS_SVH

`define SFRM_OP_NOP 8'h00
`define SFRM_OP_ARM 8'h66
`define SFRM_OP_RST 8'h99
`define SFRM_OP_SLOW 8'h03
`define SFRM_OP_FAST 8'h0B
`define SFRM_OP_ENTER_QUAD_PROTOCOL_COMMAND 8'h38
`define SFRM_OP_QEXIT 8'hFF
`define SFRM_MODE_CONT 4'hA

`define SFRM_STATUS_DEF 8'h00
`define SFRM_STATUS_KEEP 8'h30
`define SFRM_CONFIG_DEF 8'h00
`define SFRM_QIO_MASK 8'h02
`define SFRM_BURST_DEF 2'h0

`define SFRM_CLK_MHZ 250

`endif

/* core/sfrm_pkg.sv */
// types shared by the flash front end
`default_nettype none
package sfrm_pkg;
  typedef enum logic [2:0] {
    st_idle,
    st_cmd,
    st_addr,
    st_mode,
    st_dummy,
    st_data,
    st_skip
  } sfrm_state_t;
endpackage
`default_nettype wire

/* core/sfrm_sync.sv */
// two flip-flop synchroniser for pins from outside the clock domain
`default_nettype none
module sfrm_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
)(
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // pins and their synchronised copy
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_ff;

  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      meta_ff <= RST_VAL;
      q <= RST_VAL;
    end
    else
    begin
      meta_ff <= d;
      q <= meta_ff;
    end
  end
endmodule
`default_nettype wire

/* core/sfrm_fifo.sv */
// small synchronous fifo with flush, valid and ready on both sides
`default_nettype none
module sfrm_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
)(
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  input wire logic flush,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  if (DEPTH < 2 || (1 << AW) != DEPTH)
  begin : g_bad_depth
    $error("fifo depth must be a power of two, at least 2");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ff;
  logic [AW-1:0] rd_ff;
  logic [AW:0] cnt_ff;
  logic push;
  logic pop;

  assign in_ready = cnt_ff != (AW+1)'(DEPTH);
  assign out_valid = cnt_ff != '0;
  assign out_data = mem[rd_ff];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_ff @(posedge clk)
  begin
    if (push)
      mem[wr_ff] <= in_data;
  end

  // flush drops whatever is left when a frame ends
  always_ff @(posedge clk)
  begin
    if (!rst_b || flush)
    begin
      wr_ff <= '0;
      rd_ff <= '0;
      cnt_ff <= '0;
    end
    else
    begin
      wr_ff <= wr_ff + AW'(push);
      rd_ff <= rd_ff + AW'(pop);
      cnt_ff <= cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule
`default_nettype wire

/* core/sfrm_core.sv */
// serial flash command front end: software reset, protocol switch, reads
`include "sfrm_defs.svh"
`default_nettype none
module sfrm_core #(
  parameter int RCV_OTHER_NS = 40000,
  parameter int RCV_WRITE_NS = 100000,
  parameter int FIFO_DEPTH = 4
)(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // serial pins
  input wire logic sck,
  input wire logic cs_b,
  input wire logic [3:0] serial_io_lines_in,
  output logic [3:0] serial_io_lines_out,
  output logic [3:0] serial_io_lines_oe,
  // array read port
  output logic fetch_req,
  output logic [23:0] fetch_addr,
  input wire logic fetch_valid,
  input wire logic [7:0] fetch_data,
  input wire logic fetch_locked,
  // register loads from neighbouring blocks
  input wire logic status_wr,
  input wire logic [7:0] status_din,
  input wire logic config_wr,
  input wire logic [7:0] config_din,
  input wire logic burst_wr,
  input wire logic [1:0] burst_din,
  input wire logic write_busy,
  // state shown to the rest of the device
  output logic [7:0] status_reg,
  output logic [7:0] config_reg,
  output logic [1:0] burst_len,
  output logic four_bit_protocol,
  output logic reset_armed,
  output logic read_continuation,
  output logic soft_reset,
  output logic write_abort,
  output logic recovery_busy
);
  import sfrm_pkg::*;

  localparam int RCV_OT_CYC = (RCV_OTHER_NS * `SFRM_CLK_MHZ + 999) / 1000;
  localparam int RCV_WR_CYC = (RCV_WRITE_NS * `SFRM_CLK_MHZ + 999) / 1000;
  localparam int RCW = $clog2(RCV_WR_CYC + 1);

  if (RCV_OT_CYC < 1 || RCV_WR_CYC <= RCV_OT_CYC)
  begin : g_bad_recovery
    $error("write recovery must be longer than other recovery");
  end

  sfrm_state_t state_ff;
  logic sck_s;
  logic cs_s;
  logic [3:0] io_s;
  logic sck_d_ff;
  logic cs_d_ff;
  logic [2:0] bcnt_ff;
  logic [1:0] cnt_ff;
  logic [7:0] sh_ff;
  logic [7:0] opc_ff;
  logic [23:0] addr_ff;
  logic cmd_ok_ff;
  logic frm_cont_ff;
  logic [RCW-1:0] recov_cnt_ff;
  logic act_ff;
  logic pend_ff;
  logic [7:0] osh_ff;
  logic sck_rise;
  logic sck_fall;
  logic cs_fall;
  logic cs_rise;
  logic rx_phase;
  logic byte_done;
  logic addr_done;
  logic frame_cmd;
  logic pop;
  logic [2:0] step;
  logic [7:0] rx_byte;
  logic [7:0] cur;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic [7:0] fifo_out;

  sfrm_sync #(.W(6), .RST_VAL(6'h10)) u_sync (
    .clk(sys_clk),
    .rst_b(rst_b),
    .d({sck, cs_b, serial_io_lines_in}),
    .q({sck_s, cs_s, io_s})
  );

  always_ff @(posedge sys_clk)
  begin
    if (!rst_b)
    begin
      sck_d_ff <= 1'b0;
      cs_d_ff <= 1'b1;
    end
    else
    begin
      sck_d_ff <= sck_s;
      cs_d_ff <= cs_s;
    end
  end

  // frames are ignored while the device recovers from a software reset
  assign sck_rise = sck_s & ~sck_d_ff & ~cs_s;
  assign sck_fall = ~sck_s & sck_d_ff & ~cs_s;
  assign cs_fall = ~cs_s & cs_d_ff & ~recovery_busy;
  assign cs_rise = cs_s & ~cs_d_ff;
  assign step = four_bit_protocol ? 3'h4 : 3'h1;
  assign rx_byte = four_bit_protocol ? {sh_ff[3:0], io_s}
                                     : {sh_ff[6:0], io_s[0]};
  assign rx_phase = state_ff == st_cmd || state_ff == st_addr ||
                    state_ff == st_mode || state_ff == st_dummy;
  assign byte_done = sck_rise && rx_phase && (bcnt_ff + step) == 3'h0;
  assign addr_done = byte_done && state_ff == st_addr && cnt_ff == 2'h2;
  // a continuation frame has no opcode, so a quad exit there only ends it
  assign frame_cmd = cs_rise && cmd_ok_ff && !frm_cont_ff;

  // frame sequencing
  always_ff @(posedge sys_clk)
  begin
    if (!rst_b)
    begin
      state_ff <= st_idle;
      bcnt_ff <= 3'h0;
      cnt_ff <= 2'h0;
      sh_ff <= 8'h00;
      opc_ff <= 8'h00;
      addr_ff <= 24'h000000;
      cmd_ok_ff <= 1'b0;
      frm_cont_ff <= 1'b0;
    end
    else if (cs_rise)
    begin
      // a frame ignored during recovery must not replay the last command
      state_ff <= st_idle;
      cmd_ok_ff <= 1'b0;
      frm_cont_ff <= 1'b0;
    end
    else if (cs_fall)
    begin
      state_ff <= read_continuation ? st_addr : st_cmd;
      frm_cont_ff <= read_continuation;
      cmd_ok_ff <= 1'b0;
      bcnt_ff <= 3'h0;
      cnt_ff <= 2'h0;
    end
    else if (sck_rise && rx_phase)
    begin
      sh_ff <= rx_byte;
      bcnt_ff <= bcnt_ff + step;
      if (byte_done)
      begin
        case (state_ff)
          st_cmd:
          begin
            opc_ff <= rx_byte;
            cmd_ok_ff <= 1'b1;
            // slow read is not recognised in the 4-bit protocol
            if (rx_byte == `SFRM_OP_FAST)
              state_ff <= st_addr;
            else if (rx_byte == `SFRM_OP_SLOW && !four_bit_protocol)
              state_ff <= st_addr;
            else
              state_ff <= st_skip;
          end
          st_addr:
          begin
            addr_ff <= {addr_ff[15:0], rx_byte};
            cnt_ff <= cnt_ff + 2'h1;
            if (cnt_ff == 2'h2)
            begin
              cnt_ff <= 2'h0;
              if (!frm_cont_ff && opc_ff == `SFRM_OP_SLOW)
                state_ff <= st_data;
              else if (four_bit_protocol)
                state_ff <= st_mode;
              else
                state_ff <= st_dummy;
            end
          end
          st_mode:
            state_ff <= st_dummy;
          st_dummy:
          begin
            if (cnt_ff == (four_bit_protocol ? 2'h1 : 2'h0))
              state_ff <= st_data;
            else
              cnt_ff <= cnt_ff + 2'h1;
          end
          default:
            state_ff <= state_ff;
        endcase
      end
    end
    else if (sck_fall && state_ff == st_data)
      bcnt_ff <= bcnt_ff + step;
  end

  // continuation is consumed by the frame that uses it
  always_ff @(posedge sys_clk)
  begin
    if (!rst_b || soft_reset)
      read_continuation <= 1'b0;
    else if (cs_fall)
      read_continuation <= 1'b0;
    else if (byte_done && state_ff == st_mode)
      read_continuation <= rx_byte[7:4] == `SFRM_MODE_CONT;
  end

  // commands take effect when chip select rises, so half frames do nothing
  always_ff @(posedge sys_clk)
  begin
    if (!rst_b)
    begin
      reset_armed <= 1'b0;
      soft_reset <= 1'b0;
      four_bit_protocol <= 1'b0;
    end
    else
    begin
      soft_reset <= frame_cmd && opc_ff == `SFRM_OP_RST &&
                    reset_armed;
      if (frame_cmd)
        reset_armed <= opc_ff == `SFRM_OP_ARM;
      if (soft_reset)
        four_bit_protocol <= 1'b0;
      else if (frame_cmd && opc_ff == `SFRM_OP_ENTER_QUAD_PROTOCOL_COMMAND)
        four_bit_protocol <= 1'b1;
      else if (frame_cmd && opc_ff == `SFRM_OP_QEXIT)
        four_bit_protocol <= 1'b0;
    end
  end

  // lock bits survive a software reset; a reset beats a same-cycle load
  always_ff @(posedge sys_clk)
  begin
    if (!rst_b)
    begin
      status_reg <= `SFRM_STATUS_DEF;
      config_reg <= `SFRM_CONFIG_DEF;
      burst_len <= `SFRM_BURST_DEF;
    end
    else if (soft_reset)
    begin
      status_reg <= (status_reg & `SFRM_STATUS_KEEP) |
                    (`SFRM_STATUS_DEF & ~`SFRM_STATUS_KEEP);
      config_reg <= (config_reg & ~`SFRM_QIO_MASK) |
                    (`SFRM_CONFIG_DEF & `SFRM_QIO_MASK);
      burst_len <= `SFRM_BURST_DEF;
    end
    else
    begin
      if (status_wr)
        status_reg <= status_din;
      if (config_wr)
        config_reg <= config_din;
      if (burst_wr)
        burst_len <= burst_din;
    end
  end

  // recovery time depends on what the reset interrupted
  always_ff @(posedge sys_clk)
  begin
    if (!rst_b)
    begin
      recov_cnt_ff <= '0;
      recovery_busy <= 1'b0;
      write_abort <= 1'b0;
    end
    else
    begin
      write_abort <= soft_reset && write_busy;
      if (soft_reset)
      begin
        recovery_busy <= 1'b1;
        recov_cnt_ff <= write_busy ? RCW'(RCV_WR_CYC - 1)
                                   : RCW'(RCV_OT_CYC - 1);
      end
      else if (recov_cnt_ff != '0)
        recov_cnt_ff <= recov_cnt_ff - RCW'(1);
      else
        recovery_busy <= 1'b0;
    end
  end

  // one fetch in flight; the fifo's ready holds fetching back
  always_ff @(posedge sys_clk)
  begin
    if (!rst_b)
    begin
      fetch_req <= 1'b0;
      fetch_addr <= 24'h000000;
      act_ff <= 1'b0;
      pend_ff <= 1'b0;
    end
    else
    begin
      fetch_req <= 1'b0;
      if (cs_rise)
        act_ff <= 1'b0;
      else if (addr_done)
      begin
        act_ff <= 1'b1;
        fetch_addr <= {addr_ff[15:0], rx_byte};
      end
      else if (fetch_valid && pend_ff)
        fetch_addr <= fetch_addr + 24'h000001;
      if (fetch_valid)
        pend_ff <= 1'b0;
      else if (act_ff && !pend_ff && !fetch_req && fifo_in_ready &&
               !cs_rise)
      begin
        fetch_req <= 1'b1;
        pend_ff <= 1'b1;
      end
    end
  end

  sfrm_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk(sys_clk),
    .rst_b(rst_b),
    .flush(cs_rise),
    .in_valid(fetch_valid && pend_ff && act_ff),
    .in_ready(fifo_in_ready),
    .in_data(fetch_locked ? 8'h00 : fetch_data),
    .out_valid(fifo_out_valid),
    .out_ready(pop),
    .out_data(fifo_out)
  );

  // an underrun sends zero rather than stalling the host clock
  assign pop = sck_fall && state_ff == st_data && bcnt_ff == 3'h0;
  assign cur = pop ? (fifo_out_valid ? fifo_out : 8'h00) : osh_ff;

  always_ff @(posedge sys_clk)
  begin
    if (!rst_b)
    begin
      serial_io_lines_out <= 4'h0;
      serial_io_lines_oe <= 4'h0;
      osh_ff <= 8'h00;
    end
    else if (cs_rise)
      serial_io_lines_oe <= 4'h0;
    else if (sck_fall && state_ff == st_data)
    begin
      osh_ff <= four_bit_protocol ? {cur[3:0], 4'h0} : {cur[6:0], 1'b0};
      serial_io_lines_out <= four_bit_protocol ? cur[7:4]
                                               : {2'b00, cur[7], 1'b0};
      serial_io_lines_oe <= four_bit_protocol ? 4'hF : 4'h2;
    end
  end

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_b);

  AST_NOP_ONLY: assert property (
    frame_cmd && opc_ff == `SFRM_OP_NOP
    |=> !reset_armed && !soft_reset && $stable(four_bit_protocol))
    else $error("no-op changed more than the reset arm");

  AST_RST_SEQ: assert property (
    soft_reset |-> $past(reset_armed) && $past(opc_ff) == `SFRM_OP_RST)
    else $error("software reset without arm then reset");

  AST_ARM_CLEAR: assert property (
    frame_cmd && opc_ff != `SFRM_OP_ARM |=> !reset_armed)
    else $error("reset arm survived another command");

  AST_RST_STATE: assert property (
    soft_reset |=> !four_bit_protocol && burst_len == `SFRM_BURST_DEF &&
      status_reg[5:4] == $past(status_reg[5:4]))
    else $error("software reset left wrong protocol, burst or status");

  AST_RST_QIO: assert property (
    soft_reset |=> (config_reg & `SFRM_QIO_MASK) ==
      (`SFRM_CONFIG_DEF & `SFRM_QIO_MASK))
    else $error("quad io enable bit not restored");

  AST_ABORT: assert property (
    soft_reset && write_busy |=> write_abort ##1 !write_abort)
    else $error("write not aborted by software reset");

  AST_RECOV: assert property (
    soft_reset && write_busy
    |=> recovery_busy && recov_cnt_ff >= RCW'(RCV_OT_CYC))
    else $error("write recovery not longer than other recovery");

  AST_SLOW_QUAD: assert property (
    byte_done && state_ff == st_cmd && four_bit_protocol &&
    rx_byte == `SFRM_OP_SLOW |=> state_ff == st_skip)
    else $error("slow read accepted in 4-bit protocol");

  AST_QUAD_ON: assert property (
    frame_cmd && opc_ff == `SFRM_OP_ENTER_QUAD_PROTOCOL_COMMAND && !soft_reset
    |=> four_bit_protocol)
    else $error("enter-quad did not switch protocol");

  AST_QEXIT_CONT: assert property (
    cs_rise && frm_cont_ff && state_ff == st_addr && four_bit_protocol
    |=> four_bit_protocol && !read_continuation)
    else $error("quad exit in continuation left 4-bit protocol");

  AST_DRIVE_FALL: assert property (
    $changed(serial_io_lines_out) |-> $past(sck_fall))
    else $error("output data changed away from a falling edge");

  COV_SOFT_RST: cover property (soft_reset && write_busy);
  COV_CONT: cover property (cs_fall && read_continuation);
  COV_QUAD_DATA: cover property (pop && four_bit_protocol);
endmodule
`default_nettype wire

/* bench/sfrm_host.sv */
// host serial controller model: frames, byte and nibble transfers
`default_nettype none
module sfrm_host (
  // clock
  input wire logic sys_clk,
  // serial pins
  output logic sck,
  output logic cs_b,
  output logic [3:0] io_out,
  input wire logic [3:0] io_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic quad = 1'b0;
  initial
  begin
    sck = 1'b0;
    cs_b = 1'b1;
    io_out = 4'h0;
  end
  // half of the 48 ns link period
  task automatic half();
    repeat (6) @(posedge sys_clk);
  endtask
  task automatic pulse();
    half();
    sck <= 1'b1;
    half();
    sck <= 1'b0;
  endtask
  task automatic start();
    cs_b <= 1'b0;
    half();
  endtask
  // clock stands low between frames
  task automatic stop();
    half();
    cs_b <= 1'b1;
    repeat (8) @(posedge sys_clk);
  endtask
  task automatic send(input logic [7:0] b);
    if (quad)
    begin
      io_out <= b[7:4];
      pulse();
      io_out <= b[3:0];
      pulse();
    end
    else
      for (int i = 7; i >= 0; i--)
      begin
        io_out <= {3'b000, b[i]};
        pulse();
      end
  endtask
  // released lines toggle so a stale value never passes for data
  task automatic recv(output logic [7:0] b);
    int n;
    n = quad ? 2 : 8;
    b = 8'h00;
    for (int i = 0; i < n; i++)
    begin
      io_out <= ~io_out;
      half();
      b = quad ? {b[3:0], io_in} : {b[6:0], io_in[1]};
      sck <= 1'b1;
      half();
      sck <= 1'b0;
    end
  endtask
endmodule
`default_nettype wire

/* bench/sfrm_core_bench.sv */
// self-checking bench for the flash command front end
`default_nettype none
module sfrm_core_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  logic sck, cs_b, fetch_req, fetch_valid, fetch_locked;
  logic [3:0] host_io, pin_io, dut_out, dut_oe;
  logic [23:0] fetch_addr;
  logic [7:0] fetch_data, status_reg, config_reg;
  logic [1:0] burst_len, lat_ff = 2'h0;
  logic [23:0] req_addr_ff = 24'h000000;
  logic four_bit, armed, cont, soft_reset, write_abort, rcv_busy;
  logic status_wr = 1'b0, config_wr = 1'b0, burst_wr = 1'b0;
  logic write_busy = 1'b0, oe_seen = 1'b0;
  logic [7:0] status_din = 8'h00, config_din = 8'h00;
  logic [1:0] burst_din = 2'h0;
  int num_errors = 0, comparisons = 0, n_rst = 0, n_abort = 0, busy = 0;
  int busy_w;

  always #2 sys_clk = ~sys_clk;
  assign pin_io = (dut_oe & dut_out) | (~dut_oe & host_io);

  sfrm_host u_host (.sys_clk(sys_clk), .sck(sck), .cs_b(cs_b),
    .io_out(host_io), .io_in(pin_io));

  sfrm_core #(.RCV_OTHER_NS(40), .RCV_WRITE_NS(100)) u_dut (
    .sys_clk(sys_clk), .rst_b(rst_b), .sck(sck), .cs_b(cs_b),
    .serial_io_lines_in(pin_io), .serial_io_lines_out(dut_out),
    .serial_io_lines_oe(dut_oe), .fetch_req(fetch_req),
    .fetch_addr(fetch_addr), .fetch_valid(fetch_valid),
    .fetch_data(fetch_data), .fetch_locked(fetch_locked),
    .status_wr(status_wr), .status_din(status_din),
    .config_wr(config_wr), .config_din(config_din),
    .burst_wr(burst_wr), .burst_din(burst_din), .write_busy(write_busy),
    .status_reg(status_reg), .config_reg(config_reg),
    .burst_len(burst_len), .four_bit_protocol(four_bit),
    .reset_armed(armed), .read_continuation(cont),
    .soft_reset(soft_reset), .write_abort(write_abort),
    .recovery_busy(rcv_busy));

  // top byte enters by addition so a wrap differs from a stuck pointer
  function automatic logic [7:0] pat(input logic [23:0] a);
    return (a[7:0] + a[23:16]) ^ a[15:8] ^ 8'h5A;
  endfunction

  function automatic logic [7:0] exp_byte(input logic [23:0] a);
    return (a[23:16] == 8'h40) ? 8'h00 : pat(a);
  endfunction

  // array answers two cycles after each request
  always_ff @(posedge sys_clk)
  begin
    lat_ff <= {lat_ff[0], fetch_req};
    if (fetch_req)
      req_addr_ff <= fetch_addr;
  end
  assign fetch_valid = lat_ff[1];
  assign fetch_locked = req_addr_ff[23:16] == 8'h40;
  assign fetch_data = pat(req_addr_ff);

  always @(posedge sys_clk)
  begin
    n_rst += soft_reset;
    n_abort += write_abort;
    busy += rcv_busy;
    if (dut_oe != 4'h0)
      oe_seen <= 1'b1;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    comparisons++;
    if (seen !== want)
    begin
      num_errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, want);
    end
  endtask

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic frame(input logic [7:0] op);
    u_host.start();
    u_host.send(op);
    u_host.stop();
  endtask

  task automatic rd(input logic skip_op, input logic [7:0] op,
    input logic [23:0] a, input logic [7:0] mode, input int nd,
    input int n);
    logic [7:0] b;
    u_host.start();
    if (!skip_op)
      u_host.send(op);
    for (int i = 2; i >= 0; i--)
      u_host.send(a[8*i +: 8]);
    if (u_host.quad)
      u_host.send(mode);
    repeat (nd) u_host.send(8'h00);
    for (int i = 0; i < n; i++)
    begin
      u_host.recv(b);
      check(32'(b), 32'(exp_byte(24'(a + i))));
    end
    u_host.stop();
  endtask

  initial
  begin
    #200us;
    num_errors++;
    conclude();
  end

  initial
  begin
    repeat (10) @(posedge sys_clk);
    rst_b <= 1'b1;
    repeat (6) @(posedge sys_clk);
    check(32'(four_bit), 32'h0);
    check(32'(status_reg), 32'h0);
    $display("reset state done");
    status_wr <= 1'b1;
    status_din <= 8'hFF;
    config_wr <= 1'b1;
    config_din <= 8'hFF;
    burst_wr <= 1'b1;
    burst_din <= 2'h3;
    @(posedge sys_clk);
    status_wr <= 1'b0;
    config_wr <= 1'b0;
    burst_wr <= 1'b0;
    frame(8'h66);
    check(32'(armed), 32'h1);
    frame(8'h00);
    check(32'(armed), 32'h0);
    check(32'(config_reg), 32'hFF);
    frame(8'h99);
    check(32'(n_rst), 32'h0);
    frame(8'h66);
    frame(8'h38);
    u_host.quad = 1'b1;
    check(32'(armed), 32'h0);
    frame(8'h66);
    write_busy <= 1'b1;
    busy = 0;
    frame(8'h99);
    write_busy <= 1'b0;
    u_host.quad = 1'b0;
    repeat (60) @(posedge sys_clk);
    busy_w = busy;
    check(32'(n_rst), 32'h1);
    check(32'(n_abort), 32'h1);
    check(32'(status_reg), 32'h30);
    check(32'(config_reg), 32'hFD);
    check(32'(burst_len), 32'h0);
    check(32'(four_bit), 32'h0);
    $display("software reset done");
    rd(1'b0, 8'h03, 24'hFFFFFE, 8'h00, 0, 3);
    rd(1'b0, 8'h0B, 24'h00ABCD, 8'h00, 1, 2);
    $display("one-bit reads done");
    frame(8'h38);
    u_host.quad = 1'b1;
    check(32'(four_bit), 32'h1);
    rd(1'b0, 8'h0B, 24'h400001, 8'hA5, 2, 2);
    check(32'(cont), 32'h1);
    rd(1'b1, 8'h00, 24'hFFFFFF, 8'h00, 2, 2);
    check(32'(cont), 32'h0);
    rd(1'b0, 8'h0B, 24'h000100, 8'h00, 2, 1);
    oe_seen <= 1'b0;
    rd(1'b0, 8'h03, 24'h000100, 8'h00, 1, 0);
    check(32'(oe_seen), 32'h0);
    $display("four-bit reads done");
    rd(1'b0, 8'h0B, 24'h000000, 8'hA0, 2, 1);
    frame(8'hFF);
    check(32'(cont), 32'h0);
    check(32'(four_bit), 32'h1);
    frame(8'hFF);
    u_host.quad = 1'b0;
    check(32'(four_bit), 32'h0);
    frame(8'hFF);
    check(32'(four_bit), 32'h0);
    frame(8'h66);
    busy = 0;
    frame(8'h99);
    repeat (60) @(posedge sys_clk);
    check(32'(busy_w > busy), 32'h1);
    check(32'(n_abort), 32'h1);
    $display("quad exit and recovery done");
    conclude();
  end
endmodule
`default_nettype wire
